// *** hw/swc_pkg.sv ***
package swc_pkg;
  // Sleep kinds
  localparam logic [1:0] SLEEP_NONE = 2'h0;
  localparam logic [1:0] SLEEP_LIGHT = 2'h1;
  localparam logic [1:0] SLEEP_DEEP = 2'h2;
  // Entry cause codes
  localparam logic [1:0] CAUSE_NONE = 2'h0;
  localparam logic [1:0] CAUSE_WFI = 2'h1;
  localparam logic [1:0] CAUSE_WFE = 2'h2;
  localparam logic [1:0] CAUSE_EXIT = 2'h3;
  localparam logic EVENT_RESET = 1'b0;
  localparam int SYNC_STAGES = 2;
  typedef enum logic [1:0] {SWC_AWAKE, SWC_LIGHT, SWC_DEEP} swc_state_e;
endpackage : swc_pkg

// *** hw/swc_reset_sync.sv ***
`timescale 1ns/1ps
module swc_reset_sync (
  input wire logic clk,
  input wire logic resetn,
  output logic rst_sync_n
);
  import swc_pkg::*;
  logic [SYNC_STAGES-1:0] stage_r;
  // Release through two flops so every flop sees a clean deassertion edge
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stage_r <= '0;
    end else begin
      stage_r <= {stage_r[SYNC_STAGES-2:0], 1'b1};
    end
  end
  assign rst_sync_n = stage_r[SYNC_STAGES-1];
endmodule : swc_reset_sync

// *** hw/swc_event_reg.sv ***
`timescale 1ns/1ps
module swc_event_reg (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic set_event,
  input wire logic consume,
  output logic event_set
);
  import swc_pkg::*;
  typedef struct packed {
    logic ev;
  } swc_ev_s;
  swc_ev_s st_r;
  swc_ev_s st_nxt;
  // Set beats consume in the same cycle so no event is lost
  always_comb begin
    st_nxt = st_r;
    if (consume) begin
      st_nxt.ev = 1'b0;
    end
    if (set_event) begin
      st_nxt.ev = 1'b1;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '{ev: EVENT_RESET};
    end else begin
      st_r <= st_nxt;
    end
  end
  assign event_set = st_r.ev;
endmodule : swc_event_reg

// *** hw/swc_sleep_ctrl.sv ***
`timescale 1ns/1ps
// Functional notes
// - Light sleep stops only processor clock
// - Deep sleep stops system clock, PLL, flash
// - deep_sleep_select picks sleep depth
// - Non-secure deep sleep needs gate bit
// - wait_for_interrupt_op sleeps unconditionally
// - wait_for_event_op sleeps when event clear
// - wait_for_event_op with event: clear, continue
// - Event set by ext, irq, halt, send
// - Event register not software visible
// - sleep_after_handler sleeps on Thread return
// - Banked sleep_after_handler by return state
// - Interrupt-sleep wakes on entry-priority exception
// - mask_bit wakes without handler entry
// - Event-sleep also wakes on external event
// - pending_wakes_event: new pending wakes
// - pending_wakes_event banked per security state
// - Detector enabled on every sleep entry
// - Detector driven only by hardware
// - Deep sleep with detector stops tick timer; code also needs pmu_power_down
// - Wake events set event register; exception entry only while awake
module swc_sleep_ctrl (
  input wire logic clk,
  input wire logic resetn,
  input wire logic deep_sleep_select,
  input wire logic nonsecure_deep_sleep_gate,
  input wire logic secure_state,
  input wire logic wait_for_interrupt_op,
  input wire logic wait_for_event_op,
  input wire logic send_event_op,
  input wire logic ext_event_in,
  input wire logic irq_entry,
  input wire logic irq_exit,
  input wire logic halt_entry,
  input wire logic handler_return_thread,
  input wire logic return_secure,
  input wire logic sleep_after_handler_s,
  input wire logic sleep_after_handler_ns,
  input wire logic exc_entry_ready,
  input wire logic mask_bit,
  input wire logic pending_wakes_event_s,
  input wire logic pending_wakes_event_ns,
  input wire logic new_pend_s,
  input wire logic new_pend_ns,
  input wire logic pmu_power_down,
  output logic core_clk_stop,
  output logic sys_clk_stop,
  output logic pll_off_req,
  output logic flash_off_req,
  output logic wake_detect_en,
  output logic tick_timer_stop,
  output logic exec_stall,
  output logic take_handler,
  output logic sleeping,
  output logic wake_pulse
);
  import swc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    swc_state_e state;
    logic [1:0] cause;
    logic core_clk_stop;
    logic sys_clk_stop;
    logic pll_off;
    logic flash_off;
    logic wic_en;
    logic tick_stop;
    logic stall;
    logic take_handler;
    logic wake;
    logic asleep;
  } swc_ctl_s;

  // Idle, awake controller value used on wake and in default; reset repeats it inline
  function automatic swc_ctl_s swc_idle();
    swc_idle = '{state: SWC_AWAKE, cause: CAUSE_NONE, default: 1'b0};
  endfunction : swc_idle

  function automatic logic swc_is_awake(input swc_state_e s);
    swc_is_awake = (s == SWC_AWAKE);
  endfunction : swc_is_awake

  swc_ctl_s st_r;
  swc_ctl_s st_nxt;
  logic rst_n;
  logic event_set;
  logic pend_event;
  logic set_event;
  logic consume;
  logic sleep_req;
  logic deep_ok;
  logic exit_sleep;
  logic wake_now;

  swc_reset_sync u_rst (
    .clk(clk),
    .resetn(resetn),
    .rst_sync_n(rst_n)
  );

  ////////////////////////////////////////////////////////////////////////////
  // banked pending wake
  assign pend_event = (pending_wakes_event_s & new_pend_s) | (pending_wakes_event_ns & new_pend_ns);
  assign set_event = ext_event_in | irq_entry | irq_exit | halt_entry | send_event_op | pend_event
                     | (exc_entry_ready & swc_is_awake(st_r.state));
  assign consume = wait_for_event_op & event_set & swc_is_awake(st_r.state);

  // event flag kept internal, no port reads it
  swc_event_reg u_ev (
    .clk(clk),
    .rst_n(rst_n),
    .set_event(set_event),
    .consume(consume),
    .event_set(event_set)
  );

  // banked copy chosen by return state
  assign exit_sleep = handler_return_thread & (return_secure ? sleep_after_handler_s : sleep_after_handler_ns);
  assign deep_ok = deep_sleep_select & (secure_state | nonsecure_deep_sleep_gate);

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_nxt = st_r;
    st_nxt.wake = 1'b0;
    st_nxt.take_handler = 1'b0;
    sleep_req = 1'b0;
    wake_now = 1'b0;
    unique case (st_r.state)
      SWC_AWAKE: begin
        if (wait_for_interrupt_op) begin
          sleep_req = 1'b1;
          st_nxt.cause = CAUSE_WFI;
        end else if (wait_for_event_op && !event_set) begin
          sleep_req = 1'b1;
          st_nxt.cause = CAUSE_WFE;
        end else if (exit_sleep) begin
          sleep_req = 1'b1;
          st_nxt.cause = CAUSE_EXIT;
        end
        if (sleep_req) begin
          st_nxt.state = deep_ok ? SWC_DEEP : SWC_LIGHT;
          st_nxt.core_clk_stop = 1'b1;
          st_nxt.sys_clk_stop = deep_ok;
          st_nxt.pll_off = deep_ok;
          st_nxt.flash_off = deep_ok;
          st_nxt.wic_en = 1'b1;
          st_nxt.stall = 1'b1;
          st_nxt.asleep = 1'b1;
        end
      end
      SWC_LIGHT, SWC_DEEP: begin
        wake_now = exc_entry_ready
                   | ((st_r.cause == CAUSE_WFE) & (ext_event_in | pend_event));
        // power down stops the tick timer
        st_nxt.tick_stop = (st_r.state == SWC_DEEP) & st_r.wic_en & pmu_power_down;
        if (wake_now) begin
          st_nxt = swc_idle();
          st_nxt.wake = 1'b1;
          st_nxt.take_handler = exc_entry_ready & !mask_bit;
        end
      end
      default: begin
        st_nxt = swc_idle();
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '{state: SWC_AWAKE, cause: CAUSE_NONE, default: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign core_clk_stop = st_r.core_clk_stop;
  assign sys_clk_stop = st_r.sys_clk_stop;
  assign pll_off_req = st_r.pll_off;
  assign flash_off_req = st_r.flash_off;
  // detector enable is a pure hardware signal
  assign wake_detect_en = st_r.wic_en;
  assign tick_timer_stop = st_r.tick_stop;
  assign exec_stall = st_r.stall;
  assign take_handler = st_r.take_handler;
  assign sleeping = st_r.asleep;
  assign wake_pulse = st_r.wake;

  ////////////////////////////////////////////////////////////////////////////
  // sleep after interrupt wait
  chk_wfi_sleeps: assert property (@(posedge clk) disable iff (!rst_n)
    (st_r.state == SWC_AWAKE && wait_for_interrupt_op) |=> (sleeping && exec_stall))
    else $error("wait for interrupt did not sleep");
  chk_wfe_sleeps: assert property (@(posedge clk) disable iff (!rst_n)
    (st_r.state == SWC_AWAKE && wait_for_event_op && !event_set) |=> sleeping)
    else $error("wait for event with clear flag did not sleep");
  chk_wfe_consume: assert property (@(posedge clk) disable iff (!rst_n)
    (st_r.state == SWC_AWAKE && wait_for_event_op && event_set && !wait_for_interrupt_op
     && !exit_sleep && !set_event) |=> (!sleeping && !event_set))
    else $error("set event flag not consumed");
  chk_ns_deep_gate: assert property (@(posedge clk) disable iff (!rst_n)
    ($rose(sys_clk_stop)) |-> $past(secure_state || nonsecure_deep_sleep_gate))
    else $error("non-secure deep sleep not gated");
  chk_depth_select: assert property (@(posedge clk) disable iff (!rst_n)
    ($rose(sleeping)) |-> (sys_clk_stop == $past(deep_ok) && core_clk_stop))
    else $error("sleep depth mismatch");
  chk_detector_on: assert property (@(posedge clk) disable iff (!rst_n)
    sleeping |-> wake_detect_en)
    else $error("detector off during sleep");
  chk_mask_wake: assert property (@(posedge clk) disable iff (!rst_n)
    (sleeping && exc_entry_ready && mask_bit) |=> (wake_pulse && !take_handler))
    else $error("masked wake entered handler");
  chk_wfi_no_ext: assert property (@(posedge clk) disable iff (!rst_n)
    (sleeping && st_r.cause != CAUSE_WFE && !exc_entry_ready) |=> sleeping)
    else $error("interrupt sleep woke without exception");
  chk_wfe_ext_wake: assert property (@(posedge clk) disable iff (!rst_n)
    (sleeping && st_r.cause == CAUSE_WFE && ext_event_in) |=> (!sleeping ##0 wake_pulse))
    else $error("external event did not wake");
  chk_event_latch: assert property (@(posedge clk) disable iff (!rst_n)
    (send_event_op || ext_event_in) |=> event_set)
    else $error("event not latched");

  ////////////////////////////////////////////////////////////////////////////
  // light sleep keeps system running
  chk_light_clocks: assert property (@(posedge clk) disable iff (!rst_n)
    (sleeping && !sys_clk_stop) |-> (core_clk_stop && !pll_off_req && !flash_off_req))
    else $error("light sleep stopped more than the core clock");
  chk_deep_outputs: assert property (@(posedge clk) disable iff (!rst_n)
    sys_clk_stop |-> (sleeping && core_clk_stop && pll_off_req && flash_off_req))
    else $error("deep sleep outputs inconsistent");
  chk_irq_sets_event: assert property (@(posedge clk) disable iff (!rst_n)
    (irq_entry || irq_exit || halt_entry) |=> event_set)
    else $error("interrupt or halt did not set event flag");
  chk_exit_sleeps: assert property (@(posedge clk) disable iff (!rst_n)
    (swc_is_awake(st_r.state) && handler_return_thread && return_secure && sleep_after_handler_s)
    |=> sleeping)
    else $error("sleep after handler did not sleep");
  chk_exit_bank: assert property (@(posedge clk) disable iff (!rst_n)
    (swc_is_awake(st_r.state) && handler_return_thread && !wait_for_interrupt_op && !wait_for_event_op
     && !(return_secure ? sleep_after_handler_s : sleep_after_handler_ns)) |=> !sleeping)
    else $error("sleep after handler used wrong bank");
  chk_exc_wakes: assert property (@(posedge clk) disable iff (!rst_n)
    (sleeping && exc_entry_ready) |=> (!sleeping && wake_pulse))
    else $error("exception did not wake");
  chk_take_handler: assert property (@(posedge clk) disable iff (!rst_n)
    (sleeping && exc_entry_ready && !mask_bit) |=> take_handler)
    else $error("unmasked wake skipped handler");
  chk_pend_wake: assert property (@(posedge clk) disable iff (!rst_n)
    (sleeping && st_r.cause == CAUSE_WFE
     && ((pending_wakes_event_s && new_pend_s) || (pending_wakes_event_ns && new_pend_ns))) |=> !sleeping)
    else $error("new pending interrupt did not wake");
  chk_pend_bank: assert property (@(posedge clk) disable iff (!rst_n)
    (sleeping && new_pend_s && !new_pend_ns && !pending_wakes_event_s && !exc_entry_ready && !ext_event_in)
    |=> sleeping)
    else $error("pending interrupt of other state woke");
  // tick stop only in deep sleep
  chk_tick_needs_deep: assert property (@(posedge clk) disable iff (!rst_n)
    tick_timer_stop |-> (sys_clk_stop && wake_detect_en))
    else $error("tick timer stopped outside deep sleep");
  chk_tick_follows_pmu: assert property (@(posedge clk) disable iff (!rst_n)
    (sleeping && sys_clk_stop && pmu_power_down && !wake_now) |=> tick_timer_stop)
    else $error("tick timer kept running in power down");
  chk_detector_hw: assert property (@(posedge clk) disable iff (!rst_n)
    wake_detect_en |-> sleeping)
    else $error("detector enabled while awake");
  chk_event_reset: assert property (@(posedge clk) disable iff (!rst_n)
    !$past(rst_n) |-> !event_set)
    else $error("event flag set after reset");
  chk_stall_tracks: assert property (@(posedge clk) disable iff (!rst_n)
    exec_stall == sleeping)
    else $error("execution stall differs from sleep state");
  chk_handler_wake: assert property (@(posedge clk) disable iff (!rst_n)
    take_handler |-> (wake_pulse && !sleeping))
    else $error("handler entry without wake");
  chk_wake_single: assert property (@(posedge clk) disable iff (!rst_n)
    wake_pulse |=> !wake_pulse)
    else $error("wake pulse longer than one cycle");
endmodule : swc_sleep_ctrl

// *** verification/swc_pmu_model.sv ***
`timescale 1ns/1ps
module swc_pmu_model (
  input wire logic clk,
  input wire logic sys_clk_stop,
  input wire logic wake_detect_en,
  input wire logic ev_req,
  output logic pmu_power_down,
  output logic ext_event_in
);
  logic [1:0] dly_r = 2'h0;
  // power down only with detector armed
  always @(posedge clk) begin
    dly_r <= {dly_r[0], sys_clk_stop & wake_detect_en};
  end
  assign pmu_power_down = dly_r[1] & sys_clk_stop;
  // event line stays low unless a peripheral fires
  assign ext_event_in = ev_req;
endmodule : swc_pmu_model

// *** verification/tb.sv ***
`timescale 1ns/1ps
module tb;
  logic clk = 0, resetn = 0, deep_sleep_select = 0, nonsecure_deep_sleep_gate = 0, secure_state = 0;
  logic wait_for_interrupt_op = 0, wait_for_event_op = 0, send_event_op = 0, ev_req = 0, ext_event_in;
  logic irq_entry = 0, irq_exit = 0, halt_entry = 0, handler_return_thread = 0, return_secure = 0;
  logic sleep_after_handler_s = 0, sleep_after_handler_ns = 0, exc_entry_ready = 0, mask_bit = 0;
  logic pending_wakes_event_s = 0, pending_wakes_event_ns = 0, new_pend_s = 0, new_pend_ns = 0;
  logic pmu_power_down, core_clk_stop, sys_clk_stop, pll_off_req, flash_off_req, wake_detect_en;
  logic tick_timer_stop, exec_stall, take_handler, sleeping, wake_pulse, deep_seen = 0, pd_prev = 0;
  logic [2:0] n;
  logic [2:0] notes[$];
  int num_errors = 0, tests_run = 0, seed = 55208;
  swc_sleep_ctrl DUT (.clk, .resetn, .deep_sleep_select, .nonsecure_deep_sleep_gate, .secure_state,
    .wait_for_interrupt_op, .wait_for_event_op, .send_event_op, .ext_event_in, .irq_entry, .irq_exit,
    .halt_entry, .handler_return_thread, .return_secure, .sleep_after_handler_s, .sleep_after_handler_ns,
    .exc_entry_ready, .mask_bit, .pending_wakes_event_s, .pending_wakes_event_ns, .new_pend_s, .new_pend_ns,
    .pmu_power_down, .core_clk_stop, .sys_clk_stop, .pll_off_req, .flash_off_req, .wake_detect_en,
    .tick_timer_stop, .exec_stall, .take_handler, .sleeping, .wake_pulse);
  swc_pmu_model pmu (.clk, .sys_clk_stop, .wake_detect_en, .ev_req, .pmu_power_down, .ext_event_in);
  initial forever #50 clk = ~clk;
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(string nm, logic [2:0] e, logic [2:0] s);
    tests_run++;
    if (e !== s) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic tick(int k);
    repeat (k) @(negedge clk);
  endtask : tick
  task automatic pulse(ref logic s);
    s = 1;
    tick(1);
    s = 0;
  endtask : pulse
  task automatic no_sleep(ref logic op);
    pulse(op);
    tick(2);
    chk("sleeping", 0, sleeping);
  endtask : no_sleep
  // Note is {deep, take_handler, handler compared}
  task automatic sleep_wake(ref logic op, input logic [2:0] note, input logic by_ext);
    notes.push_back(note);
    pulse(op);
    tick(3 + ($random(seed) & 3));
    chk("sleeping", 1, sleeping);
    if (by_ext) pulse(ev_req);
    else pulse(exc_entry_ready);
    tick(2);
    chk("sleeping", 0, sleeping);
  endtask : sleep_wake
  task automatic close_out;
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out
  //////////////////////////////////////////////////////////////////////////////
  // Settled values are read at the falling edge, away from the design's updates
  always @(negedge clk) if (resetn) begin
    if (sleeping) begin
      deep_seen = sys_clk_stop;
      chk("asleep", 3'h7, {wake_detect_en, core_clk_stop, exec_stall});
      chk("deep", {3{sys_clk_stop}}, {sys_clk_stop, pll_off_req, flash_off_req});
      if (sys_clk_stop) chk("tick stop", pd_prev, tick_timer_stop);
    end else begin
      chk("awake", 3'h0, {wake_detect_en, core_clk_stop | sys_clk_stop | pll_off_req | flash_off_req,
        exec_stall | tick_timer_stop});
    end
    pd_prev = pmu_power_down;
    if (wake_pulse) begin
      if (notes.size() == 0) chk("note", 1, 0);
      else begin
        n = notes.pop_front();
        chk("wake", n[2:1], {deep_seen, n[0] ? take_handler : n[1]});
      end
    end
  end
  initial begin
    #(2000 * 100);
    num_errors++;
    close_out();
  end
  initial begin
    tick(5);
    resetn = 1;
    tick(3);
    sleep_wake(wait_for_event_op, 3'h1, 1);
    sleep_wake(wait_for_interrupt_op, 3'h3, 0);
    deep_sleep_select = 1;
    for (int i = 0; i < 3; i++) begin
      {secure_state, nonsecure_deep_sleep_gate} = i[1:0];
      mask_bit = (i == 2);
      sleep_wake(wait_for_interrupt_op, {i != 0, i != 2, 1'b1}, 0);
    end
    // Depth must not matter while the flag is set, so let it wander
    {deep_sleep_select, mask_bit} = {1'($random(seed)), 1'b0};
    no_sleep(wait_for_event_op);
    for (int i = 0; i < 5; i++) begin
      case (i)
        0: pulse(ev_req);
        1: pulse(irq_entry);
        2: pulse(irq_exit);
        3: pulse(halt_entry);
        default: pulse(send_event_op);
      endcase
      tick(1);
      no_sleep(wait_for_event_op);
    end
    {deep_sleep_select, pending_wakes_event_ns} = 2'h1;
    notes.push_back(3'h1);
    pulse(wait_for_event_op);
    tick(2);
    pulse(new_pend_s);
    tick(2);
    chk("sleeping", 1, sleeping);
    pulse(new_pend_ns);
    tick(2);
    chk("sleeping", 0, sleeping);
    sleep_after_handler_s = 1;
    no_sleep(handler_return_thread);
    return_secure = 1;
    sleep_wake(handler_return_thread, 3'h3, 0);
    chk("notes left", 0, notes.size() != 0);
    close_out();
  end
endmodule : tb
